//--- sid_consts.svh
// Constants for the servo input function dispatch block.
// Assumes a 100 MHz clock and 32-bit APB register access.
`ifndef SID_CONSTS_SVH
`define SID_CONSTS_SVH

`define SID_CLK_NS        10
`define SID_CAP_MAX_NS    2000000

`define SID_FN_ENABLE     16'h0001
`define SID_FN_FAULT_RST  16'h0002
`define SID_FN_ESTOP      16'h1000
`define SID_FN_HOME       16'h2000
`define SID_FN_CMD_ACT    16'h4000
`define SID_FN_MF0        16'h8004
`define SID_FN_MF1        16'h8008
`define SID_FN_MF2        16'h8010
`define SID_FN_GAIN0      16'h8020
`define SID_FN_GAIN1      16'h8040
`define SID_FN_MOTOR_FAIL 16'h8100
`define SID_FN_PRE_EN     16'h8200
`define SID_FN_CAP1       16'h8400
`define SID_FN_CAP2       16'h8800
`define SID_FN_CLR_PULSE  16'hA001
`define SID_FN_PAUSE      16'hA002
`define SID_FN_TRIM_POS   16'hA004
`define SID_FN_TRIM_NEG   16'hA008

`define SID_CW_SHUTDOWN   16'h0006
`define SID_CW_ENABLE_OP  16'h000F
`define SID_CW_CFG_RST    16'h000F
`define SID_CW_QSTOP_BIT  2
`define SID_CW_NEWSP_BIT  4
`define SID_CW_FRST_BIT   7
`define SID_CW_HALT_BIT   8

`define SID_MODE_RST      8'hFC
`define SID_MODE_PULSE    8'hFC
`define SID_MODE_HOME     8'h06

`define SID_A_FUNC0       8'h00
`define SID_A_CW_CFG      8'h20
`define SID_A_CW_SW       8'h24
`define SID_A_MODE        8'h28
`define SID_A_STATUS      8'h2C
`define SID_A_OUTS        8'h30
`define SID_A_GEAR0       8'h40
`define SID_A_CAP_FLAGS   8'h60
`define SID_A_CAP1_RISE   8'h64
`define SID_A_CAP1_FALL   8'h68
`define SID_A_CAP2_RISE   8'h6C
`define SID_A_CAP2_FALL   8'h70

`define SID_GEAR_RST      32'h03E8_03E8

`endif

//--- sid_pkg.sv
// Types for the servo input function dispatch block.
// Assumes nothing of its surroundings.
package sid_pkg;
  typedef enum logic [1:0] {
    SID_HOME_IDLE = 2'b00,
    SID_HOME_RUN  = 2'b01
  } sid_home_t;
endpackage

//--- sid_gear_mem.sv
// Gear ratio table: eight numerator/denominator pairs, registered read.
// Assumes writes and reads come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "sid_consts.svh"
module sid_gear_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [31:0]   wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [31:0]   rdData
);
  logic [31:0] memReg [DEPTH];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        memReg[i] <= `SID_GEAR_RST;
      end
    end else if (wrEn) begin
      memReg[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData <= `SID_GEAR_RST;
    end else begin
      rdData <= memReg[rdAddr];
    end
  end
endmodule // sid_gear_mem
`default_nettype wire

//--- sid_capture.sv
// One position capture channel: rising and falling edge latches.
// Assumes capIn is already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none
`include "sid_consts.svh"
module sid_capture (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        capIn,
  input  wire logic [31:0] actPos,
  input  wire logic        clrRise,
  input  wire logic        clrFall,
  output logic             riseFlag,
  output logic             fallFlag,
  output logic      [31:0] risePos,
  output logic      [31:0] fallPos
);
  logic capPrev_reg;
  logic riseEdge;
  logic fallEdge;

  assign riseEdge = capIn && !capPrev_reg;
  assign fallEdge = !capIn && capPrev_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) capPrev_reg <= 1'b0;
    else capPrev_reg <= capIn;
  end

  // A held flag protects the stored position until software clears it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      riseFlag <= 1'b0;
      risePos  <= 32'h0000_0000;
    end else if (riseEdge && (!riseFlag || clrRise)) begin
      riseFlag <= 1'b1;
      risePos  <= actPos;
    end else if (clrRise) begin
      riseFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fallFlag <= 1'b0;
      fallPos  <= 32'h0000_0000;
    end else if (fallEdge && (!fallFlag || clrFall)) begin
      fallFlag <= 1'b1;
      fallPos  <= actPos;
    end else if (clrFall) begin
      fallFlag <= 1'b0;
    end
  end

  sequence s_rise_armed;
    capIn && !capPrev_reg && !riseFlag;
  endsequence
  property p_rise_latch;
    @(posedge clk) disable iff (!reset_n)
    s_rise_armed |=> riseFlag && risePos == $past(actPos);
  endproperty
  a_rise_latch: assert property (p_rise_latch) else $error("rise capture missed");

  property p_fall_latch;
    @(posedge clk) disable iff (!reset_n)
    (!capIn && capPrev_reg && !fallFlag) |=> fallFlag && fallPos == $past(actPos);
  endproperty
  a_fall_latch: assert property (p_fall_latch) else $error("fall capture missed");

  property p_rise_hold;
    @(posedge clk) disable iff (!reset_n)
    riseFlag && !clrRise |=> riseFlag && $stable(risePos);
  endproperty
  a_rise_hold: assert property (p_rise_hold) else $error("held capture changed");
endmodule // sid_capture
`default_nettype wire

//--- sid_dispatch.sv
// Input function dispatch for a servo drive: eight inputs, APB registers.
// Assumes din comes from pins; actPos, originFound, driveEnabled are on clk.
//
// Behaviour
// - emergency stop function forces control word bit 2 low.
// - with an enable input assigned, a new enable edge re-enables instead.
// - after origin is found the previous working mode returns.
// - command activation sets the new set-point bit, as 0x2F to 0x3F.
// - multifunction inputs 0..2 form the gear table index.
// - gain switch inputs 0 and 1 form the gain set pointer.
// - motor failure input raises the external fault output.
// - capture latches actual position within 2 ms of the edge.
// - channel 1 rising edge sets its flag and stores position.
// - channel 1 falling edge sets its flag and stores position.
// - a set flag blocks new captures until host clears it.
// - channel 2 is an independent copy of channel 1.
// - pre-enable high means ready; low means not ready, enable refused.
// - clear pulse function discards received, unexecuted pulse data.
// - pause sets control word bit 8 and halts; release resumes.
// - trim inputs adjust position in pulse mode, positive or negative.
// - enable function chooses configured control word, else 0x06.
// - fault reset function sets control word bit 7.
// - function codes are hex; capture 1 is 8400, capture 2 is 8800.
`timescale 1ns/10ps
`default_nettype none
`include "sid_consts.svh"
module sid_dispatch
  import sid_pkg::*;
#(
  parameter int NIN = 8
) (
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [NIN-1:0] din,
  input  wire logic [31:0]    actPos,
  input  wire logic           originFound,
  input  wire logic           driveEnabled,
  output logic      [15:0]    ctrlWord,
  output logic      [7:0]     workMode,
  output logic      [15:0]    gearNum,
  output logic      [15:0]    gearDen,
  output logic      [1:0]     gainPtr,
  output logic                extFault,
  output logic                driveReady,
  output logic                homingStart,
  output logic                cmdActivate,
  output logic                pulseClear,
  output logic                trimPos,
  output logic                trimNeg
);
  logic [NIN-1:0] dinMeta_reg;
  logic [NIN-1:0] dinSync_reg;
  logic [15:0]    funcCode_reg [NIN];
  logic [15:0]    cwCfg_reg;
  logic [15:0]    cwSw_reg;
  logic [7:0]     modeSw_reg;
  logic [7:0]     savedMode_reg;
  sid_home_t      homeState_reg;
  logic           estopLatch_reg;
  logic           seenShutdown_reg;
  logic [15:0]    cwNext;
  logic           enPrev_reg, homePrev_reg, cmdPrev_reg, clrPrev_reg;
  logic           tpPrev_reg, tnPrev_reg;
  logic [31:0]    gearWord;
  logic [2:0]     gearIdx;
  logic           setup, wrAcc;
  logic [3:0]     capFlags;
  logic [31:0]    capPosR1, capPosF1, capPosR2, capPosF2;
  logic           cap1Lvl, cap2Lvl, clrR1, clrF1, clrR2, clrF2;
  logic           fEn, fFrst, fEstop, fHome, fCmd, fPre, fPause, fClr, fTp, fTn;
  logic           enAssigned, preAssigned, gearWr, swCwWr;

  function automatic logic fnActive(input logic [15:0] code);
    fnActive = 1'b0;
    for (int i = 0; i < NIN; i++) begin
      if (funcCode_reg[i] == code && dinSync_reg[i]) fnActive = 1'b1;
    end
  endfunction

  function automatic logic fnAssigned(input logic [15:0] code);
    fnAssigned = 1'b0;
    for (int i = 0; i < NIN; i++) begin
      if (funcCode_reg[i] == code) fnAssigned = 1'b1;
    end
  endfunction

  // Pins are asynchronous: two stages before any logic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dinMeta_reg <= '0;
      dinSync_reg <= '0;
    end else begin
      dinMeta_reg <= din;
      dinSync_reg <= dinMeta_reg;
    end
  end
  always_comb begin // Functions read the tables; an assign would not follow them
    fEn         = fnActive(`SID_FN_ENABLE);
    fFrst       = fnActive(`SID_FN_FAULT_RST);
    fEstop      = fnActive(`SID_FN_ESTOP);
    fHome       = fnActive(`SID_FN_HOME);
    fCmd        = fnActive(`SID_FN_CMD_ACT);
    fPre        = fnActive(`SID_FN_PRE_EN);
    fPause      = fnActive(`SID_FN_PAUSE);
    fClr        = fnActive(`SID_FN_CLR_PULSE);
    fTp         = fnActive(`SID_FN_TRIM_POS);
    fTn         = fnActive(`SID_FN_TRIM_NEG);
    cap1Lvl     = fnActive(`SID_FN_CAP1);
    cap2Lvl     = fnActive(`SID_FN_CAP2);
    enAssigned  = fnAssigned(`SID_FN_ENABLE);
    preAssigned = fnAssigned(`SID_FN_PRE_EN);
    gearIdx     = {fnActive(`SID_FN_MF2), fnActive(`SID_FN_MF1),
                   fnActive(`SID_FN_MF0)};
  end
  // APB slave, zero wait states; read data is captured in the setup cycle
  assign setup   = psel && !penable;
  assign wrAcc   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign gearWr  = wrAcc && paddr[7:5] == `SID_A_GEAR0 >> 5 && paddr[1:0] == 2'b00;
  assign swCwWr  = wrAcc && paddr == `SID_A_CW_SW;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (paddr < `SID_A_CW_CFG && paddr[1:0] == 2'b00) prdata <= {16'h0000, funcCode_reg[paddr[4:2]]};
      else if (paddr == `SID_A_CW_CFG)    prdata <= {16'h0000, cwCfg_reg};
      else if (paddr == `SID_A_CW_SW)     prdata <= {16'h0000, cwSw_reg};
      else if (paddr == `SID_A_MODE)      prdata <= {24'h000000, modeSw_reg};
      else if (paddr == `SID_A_STATUS)    prdata <= {15'h0000, estopLatch_reg, 8'h00, dinSync_reg};
      else if (paddr == `SID_A_OUTS)      prdata <= {gearIdx, 3'h0, gainPtr, workMode, ctrlWord};
      else if (paddr == `SID_A_CAP_FLAGS) prdata <= {28'h0000000, capFlags};
      else if (paddr == `SID_A_CAP1_RISE) prdata <= capPosR1;
      else if (paddr == `SID_A_CAP1_FALL) prdata <= capPosF1;
      else if (paddr == `SID_A_CAP2_RISE) prdata <= capPosR2;
      else if (paddr == `SID_A_CAP2_FALL) prdata <= capPosF2;
      else if (paddr[7:5] == `SID_A_GEAR0 >> 5 && paddr[1:0] == 2'b00) prdata <= 32'h0000_0000;
      else pslverr <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NIN; i++) funcCode_reg[i] <= 16'h0000;
      cwCfg_reg  <= `SID_CW_CFG_RST;
      cwSw_reg   <= `SID_CW_SHUTDOWN;
      modeSw_reg <= `SID_MODE_RST;
    end else if (wrAcc) begin
      if (paddr < `SID_A_CW_CFG && paddr[1:0] == 2'b00) funcCode_reg[paddr[4:2]] <= pwdata[15:0];
      if (paddr == `SID_A_CW_CFG) cwCfg_reg  <= pwdata[15:0];
      if (paddr == `SID_A_CW_SW)  cwSw_reg   <= pwdata[15:0];
      if (paddr == `SID_A_MODE)   modeSw_reg <= pwdata[7:0];
    end
  end

  // Writing zero to a flag bit clears it; writing one leaves it alone
  assign clrR1 = wrAcc && paddr == `SID_A_CAP_FLAGS && !pwdata[0];
  assign clrF1 = wrAcc && paddr == `SID_A_CAP_FLAGS && !pwdata[1];
  assign clrR2 = wrAcc && paddr == `SID_A_CAP_FLAGS && !pwdata[2];
  assign clrF2 = wrAcc && paddr == `SID_A_CAP_FLAGS && !pwdata[3];

  // Emergency stop latch: held until the enable edge or the 0x06, 0x0F pair
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      estopLatch_reg   <= 1'b0;
      seenShutdown_reg <= 1'b0;
    end else if (fEstop) begin
      estopLatch_reg   <= 1'b1;
      seenShutdown_reg <= 1'b0;
    end else if (estopLatch_reg) begin
      if (enAssigned) begin
        if (fEn && !enPrev_reg) estopLatch_reg <= 1'b0;
      end else if (swCwWr && pwdata[15:0] == `SID_CW_SHUTDOWN) begin
        seenShutdown_reg <= 1'b1;
      end else if (swCwWr && pwdata[15:0] == `SID_CW_ENABLE_OP && seenShutdown_reg) begin
        estopLatch_reg   <= 1'b0;
        seenShutdown_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    cwNext = enAssigned ? (fEn ? cwCfg_reg : `SID_CW_SHUTDOWN) : cwSw_reg;
    if (preAssigned && !fPre) cwNext = `SID_CW_SHUTDOWN;
    if (fEstop || estopLatch_reg) cwNext[`SID_CW_QSTOP_BIT] = 1'b0;
    if (fFrst) cwNext[`SID_CW_FRST_BIT] = 1'b1;
    if (fCmd) cwNext[`SID_CW_NEWSP_BIT] = 1'b1;
    if (fPause) cwNext[`SID_CW_HALT_BIT] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrlWord   <= `SID_CW_SHUTDOWN;
      driveReady <= 1'b0;
      extFault   <= 1'b0;
      gainPtr    <= 2'b00;
    end else begin
      ctrlWord   <= cwNext;
      driveReady <= !preAssigned || fPre;
      extFault   <= fnActive(`SID_FN_MOTOR_FAIL);
      gainPtr    <= {fnActive(`SID_FN_GAIN1), fnActive(`SID_FN_GAIN0)};
    end
  end

  // Edge detection for one-shot functions
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {enPrev_reg, homePrev_reg, cmdPrev_reg, clrPrev_reg, tpPrev_reg, tnPrev_reg} <= 6'h00;
      {cmdActivate, pulseClear, trimPos, trimNeg} <= 4'h0;
    end else begin
      {enPrev_reg, homePrev_reg, cmdPrev_reg} <= {fEn, fHome, fCmd};
      {clrPrev_reg, tpPrev_reg, tnPrev_reg}   <= {fClr, fTp, fTn};
      cmdActivate <= fCmd && !cmdPrev_reg;
      pulseClear  <= fClr && !clrPrev_reg;
      trimPos     <= fTp && !tpPrev_reg && workMode == `SID_MODE_PULSE;
      trimNeg     <= fTn && !tnPrev_reg && workMode == `SID_MODE_PULSE;
    end
  end

  // Homing: a start while disabled is ignored rather than queued
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      homeState_reg <= SID_HOME_IDLE;
      savedMode_reg <= `SID_MODE_RST;
      workMode      <= `SID_MODE_RST;
      homingStart   <= 1'b0;
    end else begin
      homingStart <= 1'b0;
      case (homeState_reg)
        SID_HOME_IDLE: begin
          workMode <= modeSw_reg;
          if (fHome && !homePrev_reg && driveEnabled) begin
            savedMode_reg <= modeSw_reg;
            workMode      <= `SID_MODE_HOME;
            homingStart   <= 1'b1;
            homeState_reg <= SID_HOME_RUN;
          end
        end
        SID_HOME_RUN: begin
          if (originFound) begin
            workMode      <= savedMode_reg;
            homeState_reg <= SID_HOME_IDLE;
          end
        end
        default: homeState_reg <= SID_HOME_IDLE;
      endcase
    end
  end

  sid_gear_mem u_gear (
    .clk     (clk),
    .reset_n (reset_n),
    .wrEn    (gearWr),
    .wrAddr  (paddr[4:2]),
    .wrData  (pwdata),
    .rdAddr  (gearIdx),
    .rdData  (gearWord)
  );
  assign gearNum = gearWord[31:16];
  assign gearDen = gearWord[15:0];

  sid_capture u_cap1 (
    .clk      (clk),
    .reset_n  (reset_n),
    .capIn    (cap1Lvl),
    .actPos   (actPos),
    .clrRise  (clrR1),
    .clrFall  (clrF1),
    .riseFlag (capFlags[0]),
    .fallFlag (capFlags[1]),
    .risePos  (capPosR1),
    .fallPos  (capPosF1)
  );

  sid_capture u_cap2 (
    .clk      (clk),
    .reset_n  (reset_n),
    .capIn    (cap2Lvl),
    .actPos   (actPos),
    .clrRise  (clrR2),
    .clrFall  (clrF2),
    .riseFlag (capFlags[2]),
    .fallFlag (capFlags[3]),
    .risePos  (capPosR2),
    .fallPos  (capPosF2)
  );

  property p_estop;
    @(posedge clk) disable iff (!reset_n) fEstop |=> !ctrlWord[`SID_CW_QSTOP_BIT];
  endproperty
  a_estop: assert property (p_estop) else $error("estop left bit 2 set");

  property p_frst;
    @(posedge clk) disable iff (!reset_n) fFrst |=> ctrlWord[`SID_CW_FRST_BIT];
  endproperty
  a_frst: assert property (p_frst) else $error("fault reset bit missing");

  property p_pause;
    @(posedge clk) disable iff (!reset_n) fPause |=> ctrlWord[`SID_CW_HALT_BIT];
  endproperty
  a_pause: assert property (p_pause) else $error("pause bit missing");

  property p_en_off;
    @(posedge clk) disable iff (!reset_n)
    enAssigned && !fEn && !fFrst && !fCmd && !fPause && !fEstop && !estopLatch_reg
    |=> ctrlWord == `SID_CW_SHUTDOWN;
  endproperty
  a_en_off: assert property (p_en_off) else $error("disabled word not 0x06");
  property p_gain;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> gainPtr == $past({fnActive(`SID_FN_GAIN1), fnActive(`SID_FN_GAIN0)});
  endproperty
  a_gain: assert property (p_gain) else $error("gain pointer wrong");

  property p_ready;
    @(posedge clk) disable iff (!reset_n)
    preAssigned && !fPre |=> !driveReady && ctrlWord[3:0] != 4'hF;
  endproperty
  a_ready: assert property (p_ready) else $error("enabled while not ready");

  sequence s_home_done;
    homeState_reg == SID_HOME_RUN && originFound;
  endsequence
  property p_home_restore;
    @(posedge clk) disable iff (!reset_n)
    s_home_done |=> workMode == $past(savedMode_reg) && homeState_reg == SID_HOME_IDLE;
  endproperty
  a_home_restore: assert property (p_home_restore) else $error("mode not restored");

  property p_gear;
    @(posedge clk) disable iff (!reset_n)
    $stable(gearIdx) && !gearWr ##1 $stable(gearIdx) && !gearWr |=> $stable(gearWord);
  endproperty
  a_gear: assert property (p_gear) else $error("gear entry unstable");
endmodule // sid_dispatch
`default_nettype wire

//--- sid_pins_model.sv
// Pin-side model: switches and host status lines feeding the dispatch block.
// Assumes bench requests arrive on clk; every line changes at a rising edge.
`timescale 1ns/10ps
`default_nettype none
module sid_pins_model (
  input  wire logic        clk,
  input  wire logic [7:0]  pinReq,
  input  wire logic [31:0] posReq,
  input  wire logic        enReq,
  input  wire logic        originReq,
  output logic      [7:0]  din,
  output logic      [31:0] actPos,
  output logic             driveEnabled,
  output logic             originFound
);
  // Switches only move at edges, so the block's synchroniser never sees a glitch
  always @(posedge clk) begin
    din <= pinReq;
    actPos <= posReq;
    driveEnabled <= enReq;
    originFound <= originReq;
  end
endmodule // sid_pins_model
`default_nettype wire

//--- sid_dispatch_test.sv
// Self-checking bench for the input function dispatch block.
// Assumes sid_pins_model drives the pins and APB answers without wait states.
`timescale 1ns/10ps
`default_nettype none
`include "sid_consts.svh"
module sid_dispatch_test import sid_pkg::*;;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        originFound, driveEnabled, extFault, driveReady, enReq, originReq;
  logic        homingStart, cmdActivate, pulseClear, trimPos, trimNeg;
  logic [7:0]  paddr, din, pinReq, workMode;
  logic [31:0] pwdata, prdata, actPos, posReq, rd;
  logic [15:0] ctrlWord, gearNum, gearDen;
  logic [1:0]  gainPtr;
  int          errorCnt, numChecks;
  logic [15:0] fnTab [2][8] = '{'{`SID_FN_ENABLE, `SID_FN_ESTOP, `SID_FN_FAULT_RST,
    `SID_FN_PAUSE, `SID_FN_CAP1, `SID_FN_CAP2, `SID_FN_MOTOR_FAIL, `SID_FN_CMD_ACT},
    '{`SID_FN_MF0, `SID_FN_MF1, `SID_FN_MF2, `SID_FN_GAIN0, `SID_FN_GAIN1,
    `SID_FN_PRE_EN, `SID_FN_HOME, `SID_FN_TRIM_POS}};
  // Pin patterns and the control word each must give; FFFF skips the check
  logic [7:0]  pinTab [9] = '{8'h00, 8'h01, 8'h05, 8'h09, 8'h81, 8'h03, 8'h01, 8'h00, 8'h01};
  logic [15:0] cwTab [9] = '{16'h0006, 16'h000F, 16'h008F, 16'h010F, 16'h001F,
    16'h000B, 16'h000B, 16'h0002, 16'h000F};

  sid_dispatch sid_dispatch_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .din, .actPos, .originFound, .driveEnabled, .ctrlWord,
    .workMode, .gearNum, .gearDen, .gainPtr, .extFault, .driveReady, .homingStart,
    .cmdActivate, .pulseClear, .trimPos, .trimNeg);
  sid_pins_model sid_pins_model_i (.clk, .pinReq, .posReq, .enReq, .originReq, .din,
    .actPos, .driveEnabled, .originFound);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // One-shot outputs except trimPos are counted so a missing or doubled pulse shows
  logic [7:0]  cmdCnt, homeCnt, clrCnt, tnCnt;
  always @(posedge clk) begin
    if (!reset_n) {cmdCnt, homeCnt, clrCnt, tnCnt} <= 32'h0;
    else {cmdCnt, homeCnt, clrCnt, tnCnt} <= {cmdCnt + 8'(cmdActivate),
      homeCnt + 8'(homingStart), clrCnt + 8'(pulseClear), tnCnt + 8'(trimNeg)};
  end

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One edge of idle first, so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errorCnt++;
      giveVerdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  task automatic cap(input int b, input int s, input logic [7:0] ra, input logic [7:0] fa);
    posReq <= 32'h1000 + s;
    pinReq[b] <= 1'b1;
    settle();
    rdchk(`SID_A_CAP_FLAGS, 32'h1 << s);
    rdchk(ra, 32'h1000 + s);
    posReq <= 32'h2000 + s;
    pinReq[b] <= 1'b0;
    settle();
    rdchk(fa, 32'h2000 + s);
    pinReq[b] <= 1'b1;
    settle();
    rdchk(ra, 32'h1000 + s);
    apb(1'b1, `SID_A_CAP_FLAGS, 32'h0);
    rdchk(`SID_A_CAP_FLAGS, 32'h0);
    pinReq[b] <= 1'b0;
    settle();
    pinReq[b] <= 1'b1;
    settle();
    rdchk(ra, 32'h2000 + s);
    apb(1'b1, `SID_A_CAP_FLAGS, 32'h0);
  endtask

  task automatic cfg(input int t);
    for (int i = 0; i < 8; i++) apb(1'b1, 8'(i * 4), {16'h0, fnTab[t][i]});
  endtask

  initial begin
    int n;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pinReq = 8'h00;
    posReq = 32'h0;
    enReq = 1'b0;
    originReq = 1'b0;
    errorCnt = 0;
    numChecks = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(`SID_A_MODE, 32'h0000_00FC);
    check(ctrlWord, `SID_CW_SHUTDOWN);
    rdchk(8'h7C, 32'h0);
    check(err, 1'b1);
    cfg(0);
    for (int i = 0; i < 9; i++) begin
      pinReq <= pinTab[i];
      settle();
      if (cwTab[i] != 16'hFFFF) check(ctrlWord, cwTab[i]);
    end
    pinReq <= 8'h40;
    settle();
    check(extFault, 1'b1);
    pinReq <= 8'h00;
    settle();
    check(extFault, 1'b0);
    cap(4, 0, `SID_A_CAP1_RISE, `SID_A_CAP1_FALL);
    cap(5, 2, `SID_A_CAP2_RISE, `SID_A_CAP2_FALL);
    pinReq <= 8'h00;
    cfg(1);
    for (int i = 0; i < 8; i++) apb(1'b1, 8'(8'h40 + i * 4), {16'(100 + i), 16'(200 + i)});
    for (int i = 0; i < 8; i++) begin
      pinReq <= {3'b001, 2'(i), 3'(i)};
      settle();
      check(gearNum, 100 + i);
      check(gearDen, 200 + i);
      check(gainPtr, i % 4);
    end
    check(driveReady, 1'b1);
    pinReq <= 8'h00;
    settle();
    check(driveReady, 1'b0);
    check(ctrlWord, `SID_CW_SHUTDOWN);
    enReq <= 1'b1;
    pinReq <= 8'h60;
    settle();
    check(workMode, `SID_MODE_HOME);
    originReq <= 1'b1;
    settle();
    check(workMode, `SID_MODE_PULSE);
    pinReq <= 8'hA0;
    n = 0;
    while (trimPos !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check(n < 20, 1'b1);
    apb(1'b1, 8'h10, {16'h0, `SID_FN_TRIM_NEG});
    apb(1'b1, 8'h18, {16'h0, `SID_FN_CLR_PULSE});
    apb(1'b1, 8'h1C, {16'h0, `SID_FN_ESTOP});
    pinReq <= 8'h70;
    apb(1'b1, `SID_A_CW_SW, {16'h0, `SID_CW_ENABLE_OP});
    settle();
    check(ctrlWord, 16'h000B);
    apb(1'b1, `SID_A_CW_SW, {16'h0, `SID_CW_SHUTDOWN});
    apb(1'b1, `SID_A_CW_SW, {16'h0, `SID_CW_ENABLE_OP});
    settle();
    check(ctrlWord, `SID_CW_ENABLE_OP);
    check({cmdCnt, homeCnt, clrCnt, tnCnt}, 32'h0101_0101);
    giveVerdict();
  end
endmodule // sid_dispatch_test
`default_nettype wire
